// ### bitw_top.sv
// Basic interval timer with watchdog, reached over a plain register port.
// Assumes a single clock; wdt_reset_o feeds the system reset, which in turn drives rst_i.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module bitw_top
  import bitw_pkg::*;
#(
  parameter int unsigned DIV_W = 10
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire logic [BITW_AW-1:0] addr_i,
  input  wire logic [BITW_DW-1:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [BITW_DW-1:0] rdata_o,
  output logic                    irq_o,
  output logic                    interval_tick_o,
  output logic                    wdt_reset_o,
  output logic                    wait_busy_o,
  output logic                    wait_done_o
);

  // Register port decode
  logic wr_mode;
  logic wr_wdt;
  logic wr_mask;
  logic wr_wait;
  logic rd_status;

  assign wr_mode   = wr_i && (addr_i == BITW_OFS_MODE);
  assign wr_wdt    = wr_i && (addr_i == BITW_OFS_WDT);
  assign wr_mask   = wr_i && (addr_i == BITW_OFS_MASK);
  assign wr_wait   = wr_i && (addr_i == BITW_OFS_WAIT);
  assign rd_status = rd_i && (addr_i == BITW_OFS_STATUS);

  // Control registers
  logic                  interval_select_r;
  logic [1:0]            pulse_sel_r;
  logic                  watchdog_enable_flag_r;
  logic [1:0]            wait_sel_r;
  logic [BITW_IRQ_N-1:0] mask_r;
  logic [BITW_IRQ_N-1:0] status_r;
  logic [BITW_IRQ_N-1:0] status_nxt;

  // Counter chain
  logic [BITW_CNT_W-1:0] interval_counter_r;
  logic                  wdt_div_r;
  logic [7:0]            wdt_count;
  logic                  count_pulse;
  logic                  interval_clear_flag;
  logic                  watchdog_service_flag;
  logic                  wdt_clear;
  logic                  overflow;
  logic                  interval_hit;
  logic                  wdt_trip;

  // Self-clearing strobes: they exist only in the write cycle, so they read 0
  assign interval_clear_flag   = wr_mode && wdata_i[BITW_MODE_CLR];
  assign watchdog_service_flag = wr_wdt && wdata_i[BITW_WDT_SVC];
  // Service before enable would only disturb the interval timer
  assign wdt_clear = watchdog_service_flag && watchdog_enable_flag_r;
  assign wdt_count = {wdt_div_r, interval_counter_r};
  assign overflow  = count_pulse && (interval_counter_r == BITW_LONG_LAST);
  assign wdt_trip  = watchdog_enable_flag_r && (wdt_count == BITW_WDT_TRIP);

  // Interval end depends on select; the counter itself is untouched on change
  always_comb begin
    if (interval_select_r) begin
      interval_hit = count_pulse && (interval_counter_r[4:0] == BITW_SHORT_LAST);
    end else begin
      interval_hit = overflow;
    end
  end

  bitw_pulse_div #(
    .W (DIV_W)
  ) u_div (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .sel_i  (pulse_sel_r),
    .tick_o (count_pulse)
  );

  bitw_wait_if wif ();

  assign wif.start = wr_wait && wdata_i[BITW_WAIT_START];
  assign wif.sel   = wait_sel_r;
  assign wif.ovf   = overflow;

  bitw_standby_wait u_wait (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .w      (wif)
  );

  assign wait_busy_o = wif.busy;

  // Mode register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      interval_select_r <= 1'b0;
      pulse_sel_r       <= BITW_PSEL_RST;
    end else if (wr_mode) begin
      interval_select_r <= wdata_i[BITW_MODE_ISEL];
      pulse_sel_r       <= wdata_i[BITW_MODE_PSEL +: 2];
    end
  end

  // Enable only ever sets; nothing but reset brings it back
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_enable_flag_r <= 1'b0;
    end else if (wr_wdt && wdata_i[BITW_WDT_EN]) begin
      watchdog_enable_flag_r <= 1'b1;
    end
  end

  // Interval counter: free running, no stop control exists
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      interval_counter_r <= BITW_CNT_RST;
    end else if (interval_clear_flag || wdt_clear) begin
      interval_counter_r <= BITW_CNT_RST;
    end else if (count_pulse) begin
      interval_counter_r <= interval_counter_r + 7'h01;
    end
  end

  // Extra divider stage; enabling does not touch the counter
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_div_r <= 1'b0;
    end else if (wdt_clear) begin
      wdt_div_r <= 1'b0;
    end else if (overflow && watchdog_enable_flag_r) begin
      wdt_div_r <= ~wdt_div_r;
    end
  end

  // Held until the system reset comes back through rst_i
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_reset_o <= 1'b0;
    end else if (wdt_trip) begin
      wdt_reset_o <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      interval_tick_o <= 1'b0;
      wait_done_o     <= 1'b0;
    end else begin
      interval_tick_o <= interval_hit && !interval_clear_flag && !wdt_clear;
      wait_done_o     <= wif.done;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_sel_r <= BITW_WSEL_RST;
    end else if (wr_wait) begin
      wait_sel_r <= wdata_i[BITW_WAIT_SEL +: 2];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_r <= BITW_IRQ_RST;
    end else if (wr_mask) begin
      mask_r <= wdata_i[BITW_IRQ_N-1:0];
    end
  end

  // Read clears, but an event in the same cycle survives
  always_comb begin
    status_nxt = rd_status ? BITW_IRQ_RST : status_r;
    if (interval_tick_o) begin
      status_nxt[BITW_IRQ_INTV] = 1'b1;
    end
    if (wait_done_o) begin
      status_nxt[BITW_IRQ_WAIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= BITW_IRQ_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign irq_o = |(status_r & mask_r);

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        BITW_OFS_MODE:   rdata_o <= {4'h0, pulse_sel_r, 1'b0, interval_select_r};
        BITW_OFS_WDT:    rdata_o <= {6'h00, watchdog_enable_flag_r, 1'b0};
        BITW_OFS_STATUS: rdata_o <= {6'h00, status_r};
        BITW_OFS_MASK:   rdata_o <= {6'h00, mask_r};
        BITW_OFS_COUNT:  rdata_o <= wdt_count;
        BITW_OFS_WAIT:   rdata_o <= {5'h00, wait_sel_r, wif.busy};
        default:         rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  logic quiet;
  assign quiet = !interval_clear_flag && !wdt_clear;

  property p_count_step;
    (count_pulse && quiet) |=> interval_counter_r == 7'($past(interval_counter_r) + 7'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter missed a pulse");

  property p_count_hold;
    (!count_pulse && quiet) |=> $stable(interval_counter_r);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without pulse");

  property p_short_period;
    (interval_hit && interval_select_r) |-> interval_counter_r[4:0] == 5'h1f;
  endproperty
  a_short_period: assert property (p_short_period) else $error("short interval at wrong count");

  property p_long_period;
    (interval_hit && !interval_select_r) |-> interval_counter_r == 7'h7f;
  endproperty
  a_long_period: assert property (p_long_period) else $error("long interval at wrong count");

  property p_select_keeps;
    (wr_mode && !wdata_i[BITW_MODE_CLR] && !count_pulse && !wdt_clear) |=> $stable(interval_counter_r);
  endproperty
  a_select_keeps: assert property (p_select_keeps) else $error("select change disturbed counter");

  property p_clear;
    interval_clear_flag |=> interval_counter_r == 7'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear flag did not zero counter");

  // The clear and service strobe bits are each checked at their own position, so a live flag cannot hide
  sequence s_mode_read;
    rd_i && (addr_i == BITW_OFS_MODE);
  endsequence
  sequence s_wdt_read;
    rd_i && (addr_i == BITW_OFS_WDT);
  endsequence
  property p_flags_read_zero;
    s_mode_read |=> rdata_o[BITW_MODE_CLR] == 1'b0;
  endproperty
  a_flags_read_zero: assert property (p_flags_read_zero) else $error("clear flag read back");
  property p_svc_read_zero;
    s_wdt_read |=> rdata_o[BITW_WDT_SVC] == 1'b0;
  endproperty
  a_svc_read_zero: assert property (p_svc_read_zero) else $error("service flag read back");

  property p_div_toggle;
    (overflow && watchdog_enable_flag_r && !wdt_clear) |=> wdt_div_r != $past(wdt_div_r);
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("divider stage did not advance");

  property p_enable_sticky;
    watchdog_enable_flag_r |=> watchdog_enable_flag_r;
  endproperty
  a_enable_sticky: assert property (p_enable_sticky) else $error("watchdog enable dropped");

  sequence s_trip;
    watchdog_enable_flag_r && wdt_count == 8'hc0;
  endsequence
  property p_trip;
    s_trip |=> wdt_reset_o [*3];
  endproperty
  a_trip: assert property (p_trip) else $error("watchdog did not hold reset");

  property p_service;
    wdt_clear |=> wdt_count == 8'h00 && !wdt_reset_o ##1 wdt_count <= 8'h01;
  endproperty
  a_service: assert property (p_service) else $error("service did not clear watchdog");

  property p_enable_no_clear;
    (wr_wdt && wdata_i[BITW_WDT_EN] && !wdata_i[BITW_WDT_SVC] && !count_pulse) |=> $stable(interval_counter_r);
  endproperty
  a_enable_no_clear: assert property (p_enable_no_clear) else $error("enable cleared counter");

  property p_irq;
    (interval_tick_o && mask_r[BITW_IRQ_INTV] && !wr_mask) |=> status_r[BITW_IRQ_INTV] && irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interval interrupt missing");

endmodule

// ### bitw_pkg.sv
// Constants, register map and types for the interval timer and watchdog.
// Assumes a single 125 MHz clock and an 8-bit register port in the same domain.
package bitw_pkg;

  localparam int unsigned BITW_AW = 8;
  localparam int unsigned BITW_DW = 8;
  localparam int unsigned BITW_CNT_W = 7;

  // Register offsets
  localparam logic [7:0] BITW_OFS_MODE   = 8'h00;
  localparam logic [7:0] BITW_OFS_WDT    = 8'h04;
  localparam logic [7:0] BITW_OFS_STATUS = 8'h08;
  localparam logic [7:0] BITW_OFS_MASK   = 8'h0c;
  localparam logic [7:0] BITW_OFS_COUNT  = 8'h10;
  localparam logic [7:0] BITW_OFS_WAIT   = 8'h14;

  // Field positions
  localparam int unsigned BITW_MODE_ISEL   = 0;
  localparam int unsigned BITW_MODE_CLR    = 1;
  localparam int unsigned BITW_MODE_PSEL   = 2;
  localparam int unsigned BITW_WDT_SVC     = 0;
  localparam int unsigned BITW_WDT_EN      = 1;
  localparam int unsigned BITW_IRQ_INTV    = 0;
  localparam int unsigned BITW_IRQ_WAIT    = 1;
  localparam int unsigned BITW_IRQ_N       = 2;
  localparam int unsigned BITW_WAIT_START  = 0;
  localparam int unsigned BITW_WAIT_SEL    = 1;

  // Reset values
  localparam logic [6:0] BITW_CNT_RST  = 7'h00;
  localparam logic [1:0] BITW_PSEL_RST = 2'h0;
  localparam logic [1:0] BITW_WSEL_RST = 2'h0;
  localparam logic [1:0] BITW_IRQ_RST  = 2'h0;

  // Counter landmarks
  localparam logic [6:0] BITW_LONG_LAST  = 7'h7f;
  localparam logic [4:0] BITW_SHORT_LAST = 5'h1f;
  localparam logic [7:0] BITW_WDT_TRIP   = 8'hc0;

  // Count pulse dividers, in clock cycles
  localparam int unsigned BITW_DIV0 = 1024;
  localparam int unsigned BITW_DIV1 = 512;
  localparam int unsigned BITW_DIV2 = 256;
  localparam int unsigned BITW_DIV3 = 64;

  // Standby-release wait, in counter overflows
  localparam logic [3:0] BITW_WAIT_N0 = 4'h1;
  localparam logic [3:0] BITW_WAIT_N1 = 4'h2;
  localparam logic [3:0] BITW_WAIT_N2 = 4'h4;
  localparam logic [3:0] BITW_WAIT_N3 = 4'h8;

  typedef enum logic [2:0] {
    BITW_W_IDLE = 3'b001,
    BITW_W_RUN  = 3'b010,
    BITW_W_DONE = 3'b100
  } bitw_wait_state_t;

endpackage

// ### bitw_wait_if.sv
// Link between the timer core and the standby-release wait timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface bitw_wait_if;
  logic       start;
  logic [1:0] sel;
  logic       ovf;
  logic       busy;
  logic       done;
  modport ctl   (output start, output sel, output ovf, input busy, input done);
  modport timer (input start, input sel, input ovf, output busy, output done);
endinterface

// ### bitw_pulse_div.sv
// Count pulse divider: one-cycle enable every selected number of clocks.
// Assumes sel_i comes from a register on the same clock.
`timescale 1ns/10ps
module bitw_pulse_div
  import bitw_pkg::*;
#(
  parameter int unsigned W = 10
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] reload;

  always_comb begin
    case (sel_i)
      2'h0:    reload = W'(BITW_DIV0 - 1);
      2'h1:    reload = W'(BITW_DIV1 - 1);
      2'h2:    reload = W'(BITW_DIV2 - 1);
      2'h3:    reload = W'(BITW_DIV3 - 1);
      default: reload = W'(BITW_DIV0 - 1);
    endcase
  end

  // Never reset by the clear flags, so the first interval may be short
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (cnt_r == '0 || cnt_r > reload) begin
      cnt_r <= reload;
    end else begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == '0);
    end
  end

endmodule

// ### bitw_standby_wait.sv
// Standby-release wait timer counting interval counter overflows.
// Assumes ovf is a one-cycle pulse from the timer core.
`timescale 1ns/10ps
module bitw_standby_wait
  import bitw_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  bitw_wait_if.timer w
);

  bitw_wait_state_t state_r;
  logic [3:0]       left_r;
  logic [3:0]       target;

  always_comb begin
    case (w.sel)
      2'h0:    target = BITW_WAIT_N0;
      2'h1:    target = BITW_WAIT_N1;
      2'h2:    target = BITW_WAIT_N2;
      2'h3:    target = BITW_WAIT_N3;
      default: target = BITW_WAIT_N0;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= BITW_W_IDLE;
      left_r  <= 4'h0;
    end else begin
      case (state_r)
        BITW_W_IDLE: begin
          if (w.start) begin
            state_r <= BITW_W_RUN;
            left_r  <= target;
          end
        end
        BITW_W_RUN: begin
          if (w.ovf) begin
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) begin
              state_r <= BITW_W_DONE;
            end
          end
        end
        BITW_W_DONE: state_r <= BITW_W_IDLE;
        default:     state_r <= BITW_W_IDLE;
      endcase
    end
  end

  assign w.busy = (state_r == BITW_W_RUN);
  assign w.done = (state_r == BITW_W_DONE);

  property p_wait_done;
    @(posedge mclk_i) disable iff (rst_i)
      (state_r == BITW_W_RUN && w.ovf && left_r == 4'h1) |=> w.done ##1 !w.busy;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("wait did not finish on last overflow");

endmodule

// ### testbench.sv
// Self-checking bench for the interval timer and watchdog block.
// Assumes a single 125 MHz clock; the bench stands in for software and the system reset.
`timescale 1ns/10ps
module testbench
  import bitw_pkg::*;
;
  logic                 mclk_i  = 1'b0;
  logic                 rst_i   = 1'b1;
  logic [BITW_AW-1:0]   addr_i  = 8'h00;
  logic [BITW_DW-1:0]   wdata_i = 8'h00;
  logic                 wr_i    = 1'b0;
  logic                 rd_i    = 1'b0;
  logic [BITW_DW-1:0]   rdata_o;
  logic                 irq_o;
  logic                 interval_tick_o;
  logic                 wdt_reset_o;
  logic                 wait_busy_o;
  logic                 wait_done_o;
  logic                 rd_d    = 1'b0;
  logic [7:0]           exp_q[$];
  logic [31:0]          rng     = 32'd15;
  logic [7:0]           rnd_v;
  int                   failures = 0;
  int                   compares = 0;
  int                   n;

  bitw_top #(.DIV_W(10)) u_dut (
    .mclk_i          (mclk_i),
    .rst_i           (rst_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rdata_o         (rdata_o),
    .irq_o           (irq_o),
    .interval_tick_o (interval_tick_o),
    .wdt_reset_o     (wdt_reset_o),
    .wait_busy_o     (wait_busy_o),
    .wait_done_o     (wait_done_o)
  );

  always #4 mclk_i = ~mclk_i;

  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv) begin
      failures++;
      $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, expv);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // Expected read data is queued here and judged by the monitor below
  task automatic rd(input logic [7:0] a, input logic [7:0] expv);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(expv);
    @(posedge mclk_i);
    rd_i   <= 1'b0;
  endtask

  // Bounded wait for 0: interval tick, 1: wait done, 2: watchdog reset
  task automatic wait_sig(input int which, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim) begin
      @(posedge mclk_i);
      cnt++;
      hit = (which == 0) ? (interval_tick_o === 1'b1) :
            (which == 1) ? (wait_done_o === 1'b1) : (wdt_reset_o === 1'b1);
    end
    if (!hit)
      check(cnt, lim + 1);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk_i) begin
    rd_d <= rd_i;
    if (rd_d) begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(rdata_o, exp_q.pop_front());
    end
  end

  // Whole run needs about 94k cycles
  initial begin
    cyc(120000);
    failures++;
    complete_run();
  end

  initial begin
    cyc(8);
    rst_i <= 1'b0;
    cyc(2);
    rd(BITW_OFS_MODE, 8'h00);
    rd(BITW_OFS_WDT, 8'h00);
    rd(BITW_OFS_STATUS, 8'h00);
    rd(BITW_OFS_MASK, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rnd_v = xorshift();
      wr(8'h18 + 8'(4 * i), rnd_v);
      rd(8'h18 + 8'(4 * i), 8'h00);
    end
    rd(BITW_OFS_MODE, 8'h00);
    // Fast pulse select, interval 128, clear strobe reads back as 0
    wr(BITW_OFS_MODE, 8'h0e);
    rd(BITW_OFS_MODE, 8'h0c);
    wr(BITW_OFS_WDT, 8'h01);
    rd(BITW_OFS_WDT, 8'h00);
    check(wdt_reset_o, 1'b0);
    // Long interval period in clock cycles
    wait_sig(0, 9000, n);
    wait_sig(0, 9000, n);
    check(n, 128 * BITW_DIV3);
    // Reads placed mid-way between count pulses
    cyc(32 + 64 * 5);
    rd(BITW_OFS_COUNT, 8'h05);
    wr(BITW_OFS_MODE, 8'h0e);
    rd(BITW_OFS_COUNT, 8'h00);
    cyc(64 * 3);
    rd(BITW_OFS_COUNT, 8'h03);
    cyc(64 * 4);
    rd(BITW_OFS_COUNT, 8'h07);
    wr(BITW_OFS_MODE, 8'h0d);
    rd(BITW_OFS_COUNT, 8'h07);
    wait_sig(0, 9000, n);
    wait_sig(0, 3000, n);
    check(n, 32 * BITW_DIV3);
    // Masked event is held in status but keeps irq low
    wr(BITW_OFS_MASK, 8'h00);
    cyc(3);
    check(irq_o, 1'b0);
    rd(BITW_OFS_STATUS, 8'h01);
    rd(BITW_OFS_STATUS, 8'h00);
    wr(BITW_OFS_MASK, 8'h01);
    wait_sig(0, 3000, n);
    cyc(3);
    check(irq_o, 1'b1);
    rd(BITW_OFS_STATUS, 8'h01);
    cyc(1);
    check(irq_o, 1'b0);
    rnd_v = xorshift();
    wr(BITW_OFS_MASK, {6'h00, rnd_v[1:0]});
    rd(BITW_OFS_MASK, {6'h00, rnd_v[1:0]});
    wr(BITW_OFS_MASK, 8'h03);
    // Standby-release wait of one overflow
    wr(BITW_OFS_WAIT, 8'h01);
    @(negedge mclk_i);
    check(wait_busy_o, 1'b1);
    rd(BITW_OFS_WAIT, 8'h01);
    wait_sig(1, 8400, n);
    check(wait_busy_o, 1'b0);
    cyc(3);
    check(irq_o, 1'b1);
    rd(BITW_OFS_STATUS, 8'h03);
    wr(BITW_OFS_MASK, 8'h00);
    // Enabling keeps the count; clear first, then service in time
    wr(BITW_OFS_MODE, 8'h0c);
    wait_sig(0, 9000, n);
    cyc(32 + 64 * 4);
    wr(BITW_OFS_WDT, 8'h02);
    rd(BITW_OFS_COUNT, 8'h04);
    wr(BITW_OFS_MODE, 8'h0e);
    rd(BITW_OFS_WDT, 8'h02);
    wr(BITW_OFS_WDT, 8'h00);
    rd(BITW_OFS_WDT, 8'h02);
    for (int i = 0; i < 3; i++) begin
      cyc(64 * 150);
      wr(BITW_OFS_WDT, 8'h03);
      rd(BITW_OFS_COUNT, 8'h00);
      check(wdt_reset_o, 1'b0);
    end
    // Servicing by interval clear alone, always before the count reaches 128
    for (int i = 0; i < 3; i++) begin
      cyc(64 * 100 - 8);
      wr(BITW_OFS_MODE, 8'h0e);
      rd(BITW_OFS_COUNT, 8'h00);
      check(wdt_reset_o, 1'b0);
    end
    // Unserviced: divider bit set at 128, trip at 192
    cyc(64 * 191);
    rd(BITW_OFS_COUNT, 8'hbf);
    check(wdt_reset_o, 1'b0);
    wait_sig(2, 70, n);
    cyc(20);
    check(wdt_reset_o, 1'b1);
    // System reset closes the loop and is the only way out
    @(posedge mclk_i);
    rst_i <= 1'b1;
    cyc(3);
    rst_i <= 1'b0;
    cyc(2);
    check(wdt_reset_o, 1'b0);
    rd(BITW_OFS_WDT, 8'h00);
    cyc(3);
    complete_run();
  end
endmodule
